/* File: hdl/ppcs_pkg.sv */
// types shared by the port pack control and switching block
package ppcs_pkg;
    typedef logic [7:0]  ppcs_byte_t;   // one bus time slot word
    typedef logic [39:0] ppcs_msg_t;    // five control slot words
    // up-link transmit state in the link domain
    typedef enum logic [2:0] {
        PPCS_UL_IDLE = 3'b001,
        PPCS_UL_WAIT = 3'b010,
        PPCS_UL_SEND = 3'b100
    } ppcs_ul_state_t;
endpackage

/* File: hdl/ppcs_regs.svh */
// constants for the port pack control and switching block
`ifndef PPCS_REGS_SVH
`define PPCS_REGS_SVH
// bus frame layout
`define PPCS_SLOTS_PER_FRAME 9'h100
`define PPCS_CTRL_SLOTS      8'h05
`define PPCS_LAST_SLOT       8'hFF
// down-link opcodes carried in the first control slot
`define PPCS_DL_OP_OOS       8'h01
`define PPCS_DL_OP_INS       8'h02
`define PPCS_DL_OP_QUERY     8'h03
`define PPCS_DL_OP_XLAT      8'h04
`define PPCS_DL_OP_UNXLAT    8'h05
// up-link opcode of the identity report
`define PPCS_UL_OP_ID        8'h81
// on-board processor reset hold, in microseconds and in clk cycles
`define PPCS_CLK_MHZ         50
`define PPCS_RST_HOLD_US     10
`define PPCS_RST_HOLD_CYC    (`PPCS_RST_HOLD_US * `PPCS_CLK_MHZ)
// sanity window, in milliseconds and in clk cycles
`define PPCS_SANITY_MS       100
`define PPCS_SANITY_CYC      (`PPCS_SANITY_MS * 1000 * `PPCS_CLK_MHZ)
// connection memory field indices that select the talk slot and the sidetone disable
`define PPCS_IDX_TALK        3'h0
`define PPCS_IDX_SIDEOFF     3'h5
`endif

/* File: hdl/ppcs_slot_switch.sv */
// one slot switch element: four ports, one talk slot and four listen paths each
`timescale 1ns/1ps
`include "ppcs_regs.svh"
module ppcs_slot_switch (
    // link clock domain
    input  wire logic         link_clk,
    input  wire logic         reset_n,
    input  wire logic         ce,
    // service state
    input  wire logic         oos,
    // connection memory write
    input  wire logic         cfg_we,
    input  wire logic [1:0]   cfg_port,
    input  wire logic [2:0]   cfg_idx,
    input  wire logic [7:0]   cfg_slot,
    input  wire logic         cfg_en,
    // bus slot position and received word
    input  wire logic [7:0]   cur_slot,
    input  wire logic [7:0]   drive_slot,
    input  wire logic [7:0]   rx_byte,
    // codec side
    input  wire logic [31:0]  tx_pcm,
    output logic [159:0]      rx_pcm,
    // bus drive request for drive_slot
    output logic              drv_en,
    output logic [7:0]        drv_data
);
    logic [7:0] talk_slot_r [4];    // talk slot per port
    logic [3:0] talk_en_r;          // talk path enabled
    logic [3:0] side_off_r;         // port makes its own sidetone
    logic [7:0] lis_slot_r  [16];   // four extra listen slots per port
    logic [15:0] lis_en_r;          // listen path enabled
    logic [3:0] talk_hit;           // port talks in drive_slot

    // connection memory, written one field at a time by the processor
    always_ff @(posedge link_clk or negedge reset_n) begin
        if (!reset_n) begin
            talk_en_r  <= '0;
            side_off_r <= '0;
            lis_en_r   <= '0;
            for (int i = 0; i < 4; i++) talk_slot_r[i] <= 8'h00;
            for (int i = 0; i < 16; i++) lis_slot_r[i] <= 8'h00;
        end else if (ce && cfg_we) begin
            if (cfg_idx == `PPCS_IDX_TALK) begin
                talk_slot_r[cfg_port] <= cfg_slot;
                talk_en_r[cfg_port]   <= cfg_en;
            end else if (cfg_idx == `PPCS_IDX_SIDEOFF) begin
                side_off_r[cfg_port] <= cfg_en;
            end else if (cfg_idx < `PPCS_IDX_SIDEOFF) begin
                lis_slot_r[{cfg_port, 2'(cfg_idx - 3'h1)}] <= cfg_slot;
                lis_en_r[{cfg_port, 2'(cfg_idx - 3'h1)}]   <= cfg_en;
            end
        end
    end

    genvar p;
    generate
        for (p = 0; p < 4; p++) begin : g_port
            assign talk_hit[p] = talk_en_r[p] && !oos && (talk_slot_r[p] == drive_slot);
        end
    endgenerate

    // lowest port wins should two ports share a talk slot
    assign drv_en   = |talk_hit;
    assign drv_data = talk_hit[0] ? tx_pcm[7:0]   :
                      talk_hit[1] ? tx_pcm[15:8]  :
                      talk_hit[2] ? tx_pcm[23:16] : tx_pcm[31:24];

    // receive paths: entry 0 is sidetone, entries 1..4 are the other slots
    always_ff @(posedge link_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_pcm <= '0;
        end else if (ce) begin
            for (int i = 0; i < 4; i++) begin
                if (talk_en_r[i] && !side_off_r[i] && talk_slot_r[i] == cur_slot)
                    rx_pcm[i*40 +: 8] <= rx_byte;
                for (int k = 0; k < 4; k++) begin
                    if (lis_en_r[i*4+k] && lis_slot_r[i*4+k] == cur_slot)
                        rx_pcm[i*40 + (k+1)*8 +: 8] <= rx_byte;
                end
            end
        end
    end
endmodule

/* File: hdl/ppcs_top.sv */
// port pack common control: control interface, slot switching, port i/o
//
// Summary of operation
// - receive down-link only in slots zero-four
// - send up-link in control slots on request
// - report slot location and vintage
// - red failure, green translated, yellow busy
// - hold processor reset at power-on
// - reset processor when heartbeat stops
// - processor takes switch elements out of service
// - drive protocol handler reset output
// - pack out of service on command/interference
// - processor scans, operates relays, runs commands
// - two switch elements serve eight ports
// - any port connects to any slot
// - talk slot sidetone plus four listens
// - sidetone disabled for self-sidetone ports
// - cabinet number from two address inputs
// - distribute processor commands to ports
// - pass port scan points to processor
// - relay drive inverted, high command energises
// - ground sensor result is a scan point
// - 256 slots, 2.048 MHz clock, 8 kHz frame
// - each slot carries one byte
`timescale 1ns/1ps
`include "ppcs_regs.svh"
module ppcs_top #(
    parameter int         SANITY_CYCLES = `PPCS_SANITY_CYC,  // sanity window
    parameter logic [7:0] VINTAGE       = 8'h5A               // arbitrary value
) (
    // system clock domain
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire logic              ce,
    // time-division bus, on the bus clock
    input  wire logic              bus_clk,
    input  wire logic              bus_frame,
    input  wire logic [7:0]        bus_data_in,
    output logic [7:0]             bus_data_out,
    output logic                   bus_data_oe,
    // backplane straps
    input  wire logic [6:0]        slot_address_inputs,
    output logic [1:0]             cabinet_number,
    // down-link messages to the processor
    output logic                   dl_valid,
    output logic [39:0]            dl_msg,
    // up-link requests from the processor
    input  wire logic              ul_req,
    input  wire logic [39:0]       ul_msg,
    output logic                   ul_busy,
    // sanity and resets
    input  wire logic              heartbeat,
    input  wire logic              ph_reset_cmd,
    output logic                   cpu_reset_n,
    output logic                   ph_reset_n,
    // status lamps and service state
    input  wire logic              circuit_busy,
    output logic                   led_red,
    output logic                   led_green,
    output logic                   led_yellow,
    output logic                   pack_oos,
    input  wire logic [1:0]        sse_oos_cmd,
    // connection memory writes
    input  wire logic              cfg_req,
    input  wire logic              cfg_sse,
    input  wire logic [1:0]        cfg_port,
    input  wire logic [2:0]        cfg_idx,
    input  wire logic [7:0]        cfg_slot,
    input  wire logic              cfg_en,
    output logic                   cfg_ready,
    // port i/o
    input  wire logic              pio_we,
    input  wire logic [2:0]        pio_port,
    input  wire logic              pio_relay,
    output logic [7:0]             relay_drive_n,
    input  wire logic [7:0]        scan_loop,
    input  wire logic [7:0]        ground_sense,
    output logic [1:0]             scan_data,
    // codec side, on the bus clock
    input  wire logic [63:0]       tx_pcm,
    output logic [319:0]           rx_pcm
);
    // ---------------- system clock domain ----------------
    logic [6:0] addr_s1_r, addr_s2_r;       // strap synchroniser
    logic [7:0] loop_s1_r, loop_s2_r;       // scan synchroniser
    logic [7:0] gnd_s1_r, gnd_s2_r;         // ground sensor synchroniser
    logic [2:0] dl_tgl_s_r, intf_tgl_s_r;   // event toggles from link side, plus edge stage
    logic [1:0] ul_ack_s_r, cfg_ack_s_r;    // handshake acks from link side
    logic       ul_tgl_r, cfg_tgl_r;        // handshake requests to link side
    ppcs_pkg::ppcs_msg_t ul_word_r;         // up-link word held across the crossing
    logic [14:0] cfg_word_r;                // {sse, port, idx, slot, en} held
    logic       id_pend_r, green_r;         // identity owed, pack translated
    logic       oos_r, fail_r;              // pack out of service, sanity failure
    logic [31:0] san_cnt_r;                 // cycles since last heartbeat
    logic [15:0] hold_cnt_r;                // processor reset hold countdown
    logic [7:0] relay_cmd_r;                // relay command per port
    ppcs_pkg::ppcs_byte_t dl_buf_r [5];     // down-link words of this frame
    logic       dl_tgl_r, intf_tgl_r;       // events toward system clock
    logic       ul_ack_r, cfg_ack_r;        // handshake acknowledges

    wire dl_evt   = dl_tgl_s_r[2] ^ dl_tgl_s_r[1];
    wire intf_evt = intf_tgl_s_r[2] ^ intf_tgl_s_r[1];
    wire ul_free  = (ul_ack_s_r[1] == ul_tgl_r);
    wire [7:0] dl_op = dl_buf_r[0];
    wire op_oos   = dl_evt && dl_op == `PPCS_DL_OP_OOS;
    wire op_ins   = dl_evt && dl_op == `PPCS_DL_OP_INS;
    wire op_query = dl_evt && dl_op == `PPCS_DL_OP_QUERY;
    wire san_out  = (san_cnt_r >= 32'(SANITY_CYCLES - 1));
    // identity report: opcode, slot location, vintage
    wire [39:0] id_word = {`PPCS_UL_OP_ID, 1'b0, addr_s2_r, VINTAGE, 16'h0000};

    // pin synchronisers run regardless of the clock enable
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            addr_s1_r <= '0;
            addr_s2_r <= '0;
            loop_s1_r <= '0;
            loop_s2_r <= '0;
            gnd_s1_r  <= '0;
            gnd_s2_r  <= '0;
        end else begin
            addr_s1_r <= slot_address_inputs;
            addr_s2_r <= addr_s1_r;
            loop_s1_r <= scan_loop;
            loop_s2_r <= loop_s1_r;
            gnd_s1_r  <= ground_sense;
            gnd_s2_r  <= gnd_s1_r;
        end
    end

    // crossings from the link side: two flops, third stage for edges
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dl_tgl_s_r   <= '0;
            intf_tgl_s_r <= '0;
            ul_ack_s_r   <= '0;
            cfg_ack_s_r  <= '0;
        end else if (ce) begin
            dl_tgl_s_r   <= {dl_tgl_s_r[1:0], dl_tgl_r};
            intf_tgl_s_r <= {intf_tgl_s_r[1:0], intf_tgl_r};
            ul_ack_s_r   <= {ul_ack_s_r[0], ul_ack_r};
            cfg_ack_s_r  <= {cfg_ack_s_r[0], cfg_ack_r};
        end
    end

    // down-link delivery and common control commands
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dl_valid  <= 1'b0;
            dl_msg    <= '0;
            oos_r     <= 1'b0;
            green_r   <= 1'b0;
            id_pend_r <= 1'b0;
        end else if (ce) begin
            dl_valid <= dl_evt;
            if (dl_evt) dl_msg <= {dl_op, dl_buf_r[1], dl_buf_r[2], dl_buf_r[3], dl_buf_r[4]};
            // command or interference removes pack; removal wins
            if (op_oos || intf_evt) oos_r <= 1'b1;
            else if (op_ins) oos_r <= 1'b0;
            if (dl_evt && dl_op == `PPCS_DL_OP_XLAT) green_r <= 1'b1;
            else if (dl_evt && dl_op == `PPCS_DL_OP_UNXLAT) green_r <= 1'b0;
            // identity owed until sent; the set wins
            if (op_query) id_pend_r <= 1'b1;
            else if (ul_free) id_pend_r <= 1'b0;
        end
    end

    // up-link launch: identity first, then a processor request
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ul_tgl_r  <= 1'b0;
            ul_word_r <= '0;
        end else if (ce && ul_free) begin
            if (id_pend_r) begin
                ul_word_r <= id_word;
                ul_tgl_r  <= ~ul_tgl_r;
            end else if (ul_req) begin
                ul_word_r <= ul_msg;
                ul_tgl_r  <= ~ul_tgl_r;
            end
        end
    end

    // connection memory request, held until the link side acknowledges
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_tgl_r  <= 1'b0;
            cfg_word_r <= '0;
        end else if (ce && cfg_req && cfg_ack_s_r[1] == cfg_tgl_r) begin
            cfg_word_r <= {cfg_sse, cfg_port, cfg_idx, cfg_slot, cfg_en};
            cfg_tgl_r  <= ~cfg_tgl_r;
        end
    end

    // sanity watch and processor reset hold
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            san_cnt_r  <= '0;
            hold_cnt_r <= 16'(`PPCS_RST_HOLD_CYC);
            fail_r     <= 1'b0;
        end else if (ce) begin
            if (hold_cnt_r != 16'h0000) begin
                hold_cnt_r <= hold_cnt_r - 16'h0001;
                san_cnt_r  <= '0;
            end else if (heartbeat) begin
                san_cnt_r <= '0;
                fail_r    <= 1'b0;
            end else if (san_out) begin
                san_cnt_r  <= '0;
                hold_cnt_r <= 16'(`PPCS_RST_HOLD_CYC);
                fail_r     <= 1'b1;
            end else begin
                san_cnt_r <= san_cnt_r + 32'h0000_0001;
            end
        end
    end

    // registered outputs on the system clock
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cpu_reset_n    <= 1'b0;
            ph_reset_n     <= 1'b0;
            led_red        <= 1'b1;
            led_green      <= 1'b0;
            led_yellow     <= 1'b0;
            pack_oos       <= 1'b0;
            ul_busy        <= 1'b0;
            cfg_ready      <= 1'b1;
            cabinet_number <= 2'h0;
            relay_cmd_r    <= '0;
            relay_drive_n  <= 8'hFF;
            scan_data      <= 2'h0;
        end else if (ce) begin
            cpu_reset_n <= (hold_cnt_r == 16'h0000);
            // handler held with the processor or on command
            ph_reset_n  <= (hold_cnt_r == 16'h0000) && !ph_reset_cmd;
            led_red     <= fail_r || oos_r || hold_cnt_r != 16'h0000;
            led_green   <= green_r;
            led_yellow  <= circuit_busy;
            pack_oos    <= oos_r;
            ul_busy     <= !ul_free || id_pend_r;
            cfg_ready   <= (cfg_ack_s_r[1] == cfg_tgl_r) && !cfg_req;
            // cabinet from the two inputs below the top strap
            cabinet_number <= addr_s2_r[5:4];
            if (pio_we) relay_cmd_r[pio_port] <= pio_relay;
            // inverted drive energises on high command
            relay_drive_n <= ~relay_cmd_r;
            // scan points, ground sensor in bit 1
            scan_data <= {gnd_s2_r[pio_port], loop_s2_r[pio_port]};
        end
    end

    // ---------------- bus clock domain ----------------
    logic [1:0] rst_l_r;                    // reset release on the bus clock
    logic [1:0] ce_l_r;                     // clock enable synchroniser
    logic [1:0] oos_l_r;                    // pack out of service
    logic [3:0] sse_oos_l_r;                // per element out of service
    logic [2:0] ul_tgl_l_r, cfg_tgl_l_r;    // request toggles, plus edge stage
    logic [7:0] slot_r;                     // current time slot
    logic       ul_oe_r;                    // bus word now out is up-link
    ppcs_pkg::ppcs_ul_state_t ul_st_r;      // up-link transmit state
    logic [1:0] sse_en;                     // element drive requests
    logic [15:0] sse_dat;                   // element drive words

    wire ce_l  = ce_l_r[1];
    wire oos_l = oos_l_r[1];
    wire [7:0] cur_slot   = bus_frame ? 8'h00 : slot_r + 8'h01;
    wire [7:0] drive_slot = cur_slot + 8'h01;
    wire in_ctrl    = cur_slot < `PPCS_CTRL_SLOTS;
    wire drv_ctrl   = drive_slot < `PPCS_CTRL_SLOTS;
    wire ul_new     = ul_tgl_l_r[2] ^ ul_tgl_l_r[1];
    wire cfg_new    = cfg_tgl_l_r[2] ^ cfg_tgl_l_r[1];
    wire ul_drive   = (ul_st_r == ppcs_pkg::PPCS_UL_SEND) && drv_ctrl && !oos_l;
    wire [7:0] ul_byte = ul_word_r[8*(4 - int'(drive_slot[2:0])) +: 8];
    // own up-link word corrupted on the bus
    wire intf_hit   = ul_oe_r && (bus_data_in != bus_data_out);

    // reset release and level crossings into the bus clock domain
    always_ff @(posedge bus_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_l_r     <= '0;
            ce_l_r      <= '0;
            oos_l_r     <= '0;
            sse_oos_l_r <= '0;
            ul_tgl_l_r  <= '0;
            cfg_tgl_l_r <= '0;
        end else begin
            rst_l_r     <= {rst_l_r[0], 1'b1};
            ce_l_r      <= {ce_l_r[0], ce};
            oos_l_r     <= {oos_l_r[0], oos_r};
            sse_oos_l_r <= {sse_oos_l_r[1:0], sse_oos_cmd};
            ul_tgl_l_r  <= {ul_tgl_l_r[1:0], ul_tgl_r};
            cfg_tgl_l_r <= {cfg_tgl_l_r[1:0], cfg_tgl_r};
        end
    end

    // slot counting, down-link capture and connection writes
    always_ff @(posedge bus_clk or negedge reset_n) begin
        if (!reset_n) begin
            slot_r     <= `PPCS_LAST_SLOT;
            dl_tgl_r   <= 1'b0;
            intf_tgl_r <= 1'b0;
            cfg_ack_r  <= 1'b0;
            for (int i = 0; i < 5; i++) dl_buf_r[i] <= 8'h00;
        end else if (ce_l) begin
            // 256 slots wrap naturally in eight bits
            slot_r <= cur_slot;
            if (in_ctrl) dl_buf_r[cur_slot[2:0]] <= bus_data_in;
            // last control slot completes the message
            if (cur_slot == `PPCS_CTRL_SLOTS - 8'h01) dl_tgl_r <= ~dl_tgl_r;
            if (intf_hit) intf_tgl_r <= ~intf_tgl_r;
            if (cfg_new) cfg_ack_r <= cfg_tgl_l_r[1];
        end
    end

    // up-link transmit: wait for a frame, send slots zero to four
    always_ff @(posedge bus_clk or negedge reset_n) begin
        if (!reset_n) begin
            ul_st_r  <= ppcs_pkg::PPCS_UL_IDLE;
            ul_ack_r <= 1'b0;
        end else if (ce_l) begin
            case (ul_st_r)
                ppcs_pkg::PPCS_UL_IDLE: begin
                    if (ul_new) ul_st_r <= ppcs_pkg::PPCS_UL_WAIT;
                end
                ppcs_pkg::PPCS_UL_WAIT: begin
                    // start at a frame edge in the control slots
                    if (drive_slot == `PPCS_LAST_SLOT) ul_st_r <= ppcs_pkg::PPCS_UL_SEND;
                end
                ppcs_pkg::PPCS_UL_SEND: begin
                    if (drive_slot == `PPCS_CTRL_SLOTS) begin
                        ul_st_r  <= ppcs_pkg::PPCS_UL_IDLE;
                        ul_ack_r <= ul_tgl_l_r[1];
                    end
                end
                default: ul_st_r <= ppcs_pkg::PPCS_UL_IDLE;
            endcase
        end
    end

    // bus drivers, registered one slot ahead of their slot
    always_ff @(posedge bus_clk or negedge reset_n) begin
        if (!reset_n) begin
            bus_data_out <= 8'h00;
            bus_data_oe  <= 1'b0;
            ul_oe_r      <= 1'b0;
        end else if (ce_l) begin
            ul_oe_r <= ul_drive;
            // nothing on the bus while the pack is out
            bus_data_oe  <= rst_l_r[1] && !oos_l && (ul_drive || |sse_en);
            bus_data_out <= ul_drive ? ul_byte : (sse_en[0] ? sse_dat[7:0] : sse_dat[15:8]);
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_sse
            ppcs_slot_switch u_sse (
                .link_clk   (bus_clk),
                .reset_n    (reset_n),
                .ce         (ce_l),
                .oos        (sse_oos_l_r[g+2] || oos_l),
                .cfg_we     (cfg_new && cfg_word_r[14] == 1'(g)),
                .cfg_port   (cfg_word_r[13:12]),
                .cfg_idx    (cfg_word_r[11:9]),
                .cfg_slot   (cfg_word_r[8:1]),
                .cfg_en     (cfg_word_r[0]),
                .cur_slot   (cur_slot),
                .drive_slot (drive_slot),
                .rx_byte    (bus_data_in),
                .tx_pcm     (tx_pcm[g*32 +: 32]),
                .rx_pcm     (rx_pcm[g*160 +: 160]),
                .drv_en     (sse_en[g]),
                .drv_data   (sse_dat[g*8 +: 8])
            );
        end
    endgenerate
endmodule

/* File: test/ppcs_cc_model.sv */
// central control model: frames the bus, sends down-link, collects up-link
`timescale 1ns/1ps
module ppcs_cc_model (
    // bus clock and bench requests
    input  wire logic        bus_clk, go, jam,
    input  wire logic [39:0] msg,
    // pack side of the bus
    input  wire logic [7:0]  bus_data_out,
    input  wire logic        bus_data_oe,
    output logic             bus_frame,
    output logic [7:0]       bus_data_in,
    output logic [39:0]      got
);
    logic [7:0] s = 8'h00;   // slot now on the bus
    logic [7:0] w = 8'h00;   // word from central control
    logic       arm = 1'b0;  // down-link sent in this frame
    wire  logic [7:0] n = s + 8'h01;
    wire  logic       send = (s == 8'hFF) ? go : arm;
    initial bus_frame = 1'b0;
    // terminated bus reads zero when idle; jam spoils the pack's word
    assign bus_data_in = bus_data_oe ? (bus_data_out ^ {7'h00, jam}) : w;
    // 256 one-byte slots, control traffic in slots 0-4
    always @(posedge bus_clk) begin
        if (bus_data_oe && s < 8'h05)
            got[39 - 8 * s -: 8] <= bus_data_out;
        if (s == 8'hFF)
            arm <= go;
        w <= (send && n < 8'h05) ? msg[39 - 8 * n -: 8] : 8'h00;
        bus_frame <= (n == 8'h00);
        s <= n;
    end
endmodule

/* File: test/ppcs_top_chk.sv */
// checker on the pack's top ports
`timescale 1ns/1ps
module ppcs_top_chk (
    // clocks and reset
    input wire logic       clk, bus_clk, reset_n,
    // watched ports
    input wire logic [6:0] slot_address_inputs,
    input wire logic [1:0] cabinet_number, sse_oos_cmd,
    input wire logic       circuit_busy, led_yellow, dl_valid, ul_req, ul_busy,
    input wire logic       cfg_req, cfg_ready, ph_reset_cmd, ph_reset_n,
    input wire logic       pack_oos, bus_data_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // a connection write taken by the pack
    sequence cfg_take;
        cfg_req && cfg_ready;
    endsequence
    // straps pass two sync stages, so they must hold a while first
    cab_decode_a: assert property ($stable(slot_address_inputs)[*5]
        |-> cabinet_number == slot_address_inputs[5:4]) else $error("cabinet decode");
    busy_lamp_a: assert property ($stable(circuit_busy)[*4]
        |-> led_yellow == circuit_busy) else $error("busy lamp");
    dl_pulse_a: assert property (dl_valid |=> !dl_valid) else $error("dl pulse");
    ul_take_a: assert property ($rose(ul_busy)
        |-> $past(ul_req, 2) || $past(dl_valid)) else $error("ul busy");
    cfg_take_a: assert property (cfg_take |=> !cfg_ready) else $error("cfg ready");
    ph_reset_a: assert property (ph_reset_cmd[*4] |-> !ph_reset_n) else $error("ph rst");
    // oos crosses into the bus domain, hence the settling span
    pack_quiet_a: assert property (@(posedge bus_clk) disable iff (!reset_n)
        pack_oos[*6] |-> !bus_data_oe) else $error("oos pack drives");
    sse_quiet_a: assert property (@(posedge bus_clk) disable iff (!reset_n)
        (sse_oos_cmd == 2'h3 && !ul_busy)[*8] |-> !bus_data_oe) else $error("oos sse drives");
endmodule
bind ppcs_top ppcs_top_chk u_chk (.*);

/* File: test/tb.sv */
// self-checking bench for the port pack control block
`timescale 1ns/1ps
module tb;
    logic clk = 0, bus_clk = 0, reset_n = 0, ce = 1, bus_frame, bus_data_oe, dl_valid, hb_on = 1;
    logic [7:0] bus_data_in, bus_data_out, relay_drive_n, scan_loop = 0, ground_sense = 0;
    logic [6:0] slot_address_inputs = 0;
    logic [1:0] cabinet_number, sse_oos_cmd = 0, scan_data, cfg_port = 0;
    logic [39:0] dl_msg, ul_msg = 0, msg = 0, got;
    logic ul_req = 0, ul_busy, heartbeat = 0, ph_reset_cmd = 0, cpu_reset_n, ph_reset_n;
    logic circuit_busy = 0, led_red, led_green, led_yellow, pack_oos, go = 0, jam = 0;
    logic cfg_req = 0, cfg_sse = 0, cfg_en = 1, cfg_ready, pio_we = 0, pio_relay = 0;
    logic [2:0] cfg_idx = 0, pio_port = 0;
    logic [7:0] cfg_slot = 8'h03;
    logic [63:0] tx_pcm = 0;
    logic [319:0] rx_pcm;
    int seed = 88471, mismatches = 0, comparisons = 0, i, oe_seen = 0;
    // short sanity window; vintage value is arbitrary
    ppcs_top #(.SANITY_CYCLES(200), .VINTAGE(8'h3C)) dut (.*);
    ppcs_cc_model cc (.*);
    always #10 clk = ~clk;
    initial begin
        #7;
        forever #40 bus_clk = ~bus_clk;
    end
    // heartbeat every 50 cycles while the processor is sane
    always begin
        tick(49);
        heartbeat = hb_on;
        tick(1);
        heartbeat = 0;
    end
    always @(posedge bus_clk) oe_seen += bus_data_oe;
    task automatic chk(string n, logic [39:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s exp %h seen %h", n, exp, seen);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // one down-link message; then a frame passes so no repeat is mistaken
    task automatic dl(logic [7:0] op);
        msg = {op, 32'($random(seed))};
        go = 1;
        for (i = 0; i < 3000 && (dl_valid !== 1'b1 || dl_msg[39:32] !== op); i++) tick(1);
        go = 0;
        chk("dl_msg", dl_msg, msg);
        tick(1100);
        $display("down-link %h done", op);
    endtask
    task automatic ul;
        ul_msg = {1'b1, 31'($random(seed)), 8'($random(seed))};
        ul_req = 1;
        tick(1);
        ul_req = 0;
        for (i = 0; i < 4000 && (i < 3 || ul_busy !== 1'b0); i++) tick(1);
        tick(20);
    endtask
    initial begin
        tx_pcm = {$random(seed), $random(seed)};
        // top strap low, the rest unique
        slot_address_inputs = 7'($random(seed)) & 7'h3F;
        tick(20);
        chk("relay idle", relay_drive_n, 8'hFF);
        reset_n = 1;
        tick(510);
        chk("startup", cpu_reset_n, 1);
        chk("cabinet", cabinet_number, slot_address_inputs[5:4]);
        for (int p = 0; p < 8; p++) begin
            pio_port = 3'(p);
            pio_relay = 1'($random(seed));
            pio_we = 1;
            tick(1);
            pio_we = 0;
            scan_loop = 8'($random(seed));
            ground_sense = 8'($random(seed));
            circuit_busy = pio_relay;
            tick(5);
            chk("relay", relay_drive_n[p], !pio_relay);
            chk("scan", scan_data, {ground_sense[p], scan_loop[p]});
        end
        ph_reset_cmd = 1;
        tick(6);
        ph_reset_cmd = 0;
        dl(8'h04);
        chk("green", led_green, 1);
        dl(8'h05);
        chk("green", led_green, 0);
        dl(8'h03);
        tick(1100);
        chk("id", got, {8'h81, 1'b0, slot_address_inputs, 8'h3C, 16'h0000});
        dl(8'h01);
        chk("oos", pack_oos, 1);
        dl(8'h02);
        chk("ins", pack_oos, 0);
        ul;
        chk("uplink", got, ul_msg);
        jam = 1;
        ul;
        jam = 0;
        chk("jam", pack_oos, 1);
        dl(8'h02);
        cfg_req = 1;
        tick(1);
        cfg_req = 0;
        for (i = 0; i < 500 && cfg_ready !== 1'b1; i++) tick(1);
        tick(2200);
        chk("talk", got[15:8], tx_pcm[7:0]);
        chk("side", rx_pcm[7:0], tx_pcm[7:0]);
        sse_oos_cmd = 2'h3;
        tick(200);
        oe_seen = 0;
        tick(1100);
        chk("sse oos", 40'(oe_seen), 0);
        hb_on = 0;
        tick(300);
        chk("sanity", cpu_reset_n, 0);
        chk("red", led_red, 1);
        report_and_stop;
    end
    initial begin
        tick(60000);
        mismatches++;
        report_and_stop;
    end
endmodule
